// ===== include/mssp_regs.vh
// Register addresses, commands and timing counts for the motion serial port
`ifndef MSSP_REGS_VH
`define MSSP_REGS_VH
`define MSSP_ADDR_MOTION    7'h02
`define MSSP_ADDR_DX        7'h03
`define MSSP_ADDR_DY        7'h04
`define MSSP_ADDR_SQUAL     7'h05
`define MSSP_ADDR_SHUT_HI   7'h06
`define MSSP_ADDR_SHUT_LO   7'h07
`define MSSP_ADDR_PEAK      7'h08
`define MSSP_ADDR_PUP_RST   7'h3a
`define MSSP_ADDR_BURST     7'h42
`define MSSP_PUP_RST_KEY    8'h5a
`define MSSP_BURST_BYTES    3'd7
`define MSSP_CLK_MHZ        100
// Downshift delays and rest-level check periods, in microseconds
`define MSSP_DS1_US         237000
`define MSSP_DS2_US         8400000
`define MSSP_DS3_US         504000000
`define MSSP_CHK1_US        16500
`define MSSP_CHK2_US        82000
`define MSSP_CHK3_US        410000
`define MSSP_DS1_CYC        (64'd1 * `MSSP_DS1_US * `MSSP_CLK_MHZ)
`define MSSP_DS2_CYC        (64'd1 * `MSSP_DS2_US * `MSSP_CLK_MHZ)
`define MSSP_DS3_CYC        (64'd1 * `MSSP_DS3_US * `MSSP_CLK_MHZ)
`define MSSP_CHK1_CYC       (64'd1 * `MSSP_CHK1_US * `MSSP_CLK_MHZ)
`define MSSP_CHK2_CYC       (64'd1 * `MSSP_CHK2_US * `MSSP_CLK_MHZ)
`define MSSP_CHK3_CYC       (64'd1 * `MSSP_CHK3_US * `MSSP_CLK_MHZ)
`endif

// ===== hdl/mssp_port.v
// Serial slave port, motion flag and rest-level sequencing
`include "mssp_regs.vh"

// Overview of operation
// - Downshift through three rest levels by idle time
// - Check motion at each rest level's period
// - Motion pin low while moved flag set
// - Clear flag on both deltas read or write
// - Deselected: ignore inputs, release data out
// - Select rising mid-transfer aborts, port resets
// - Write: address byte with msb one, data
// - Read: address msb zero, device returns byte
// - Sample input rising, change output falling
// - Output bit held until next falling edge
// - Burst read at 0x42 streams seven bytes
// - Burst may end any time after X
// - Burst values latched at last address bit
// - After burst refuse all until deselect
// - Full reset only on 0x5a to 0x3a
module mssp_port #(
  parameter [63:0] DS1_CYC  = `MSSP_DS1_CYC,
  parameter [63:0] DS2_CYC  = `MSSP_DS2_CYC,
  parameter [63:0] DS3_CYC  = `MSSP_DS3_CYC,
  parameter [63:0] CHK1_CYC = `MSSP_CHK1_CYC,
  parameter [63:0] CHK2_CYC = `MSSP_CHK2_CYC,
  parameter [63:0] CHK3_CYC = `MSSP_CHK3_CYC
) (
  // Clock and reset
  input  wire       clk_sys,
  input  wire       rst_n,
  // Serial pins
  input  wire       port_select_low,
  input  wire       ser_clk,
  input  wire       ser_din,
  output reg        ser_dout,
  output reg        ser_dout_oe,
  // Motion sensing core
  input  wire       motion_event,
  input  wire [7:0] motion_dx,
  input  wire [7:0] motion_dy,
  input  wire [7:0] squal,
  input  wire [15:0] shutter,
  input  wire [7:0] peak_pixel,
  // Status and control
  output reg        motion_low,
  output reg  [1:0] rest_level,
  output reg        motion_check,
  output reg        core_reset,
  output reg        cfg_wr,
  output reg  [6:0] cfg_addr,
  output reg  [7:0] cfg_data
);

  //--------------------------------------------------------------
  // Pin synchronisers and edge detection
  //--------------------------------------------------------------
  reg [1:0] cs_s_q, sck_s_q, din_s_q;
  reg       sck_d1_q;
  wire      sel     = ~cs_s_q[1];
  wire      sck_r   = sel & sck_s_q[1] & ~sck_d1_q;
  wire      sck_f   = sel & ~sck_s_q[1] & sck_d1_q;

  // Two flops per pin; only the second stage feeds logic
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cs_s_q   <= 2'h3;
      sck_s_q  <= 2'h3;
      din_s_q  <= 2'h0;
      sck_d1_q <= 1'b1;
    end else begin
      cs_s_q   <= {cs_s_q[0], port_select_low};
      sck_s_q  <= {sck_s_q[0], ser_clk};
      din_s_q  <= {din_s_q[0], ser_din};
      sck_d1_q <= sck_s_q[1];
    end
  end

  //--------------------------------------------------------------
  // Serial transaction engine
  //--------------------------------------------------------------
  localparam [3:0] ST_ADDR = 4'h1, ST_WDAT = 4'h2, ST_RDAT = 4'h4,
                   ST_LOCK = 4'h8;

  reg [3:0]  st_q;
  reg [2:0]  bit_q;
  reg [2:0]  bidx_q;     // burst byte index
  reg [7:0]  sh_q;       // input shift
  reg [7:0]  tx_q;       // output shift
  reg [6:0]  addr_q;
  reg        burst_q;
  reg        oe_arm_q;
  reg [55:0] bbuf_q;     // burst snapshot, first byte in top
  reg [7:0]  dx_q, dy_q;
  reg        moved_flag, dx_rd_q, dy_rd_q;
  wire [7:0] sh_in = {sh_q[6:0], din_s_q[1]};

  // Register read mux; unmapped addresses read zero
  function [7:0] rd_mux;
    input [6:0] a;
    begin
      case (a)
        `MSSP_ADDR_MOTION:  rd_mux = {moved_flag, 7'h00};
        `MSSP_ADDR_DX:      rd_mux = dx_q;
        `MSSP_ADDR_DY:      rd_mux = dy_q;
        `MSSP_ADDR_SQUAL:   rd_mux = squal;
        `MSSP_ADDR_SHUT_HI: rd_mux = shutter[15:8];
        `MSSP_ADDR_SHUT_LO: rd_mux = shutter[7:0];
        `MSSP_ADDR_PEAK:    rd_mux = peak_pixel;
        default:            rd_mux = 8'h00;
      endcase
    end
  endfunction

  wire addr_done = (st_q == ST_ADDR) & sck_r & (bit_q == 3'd7);
  wire wr_done   = (st_q == ST_WDAT) & sck_r & (bit_q == 3'd7);
  wire rd_byte   = (st_q == ST_RDAT) & sck_r & (bit_q == 3'd7);
  wire wr_motion = wr_done & (addr_q == `MSSP_ADDR_MOTION);

  // Deselect aborts everything; counters restart on every select
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_ADDR; bit_q <= 3'd0; bidx_q <= 3'd0;
      sh_q <= 8'h00; tx_q <= 8'h00; addr_q <= 7'h00;
      burst_q <= 1'b0; oe_arm_q <= 1'b0; bbuf_q <= 56'h0;
      ser_dout <= 1'b0; ser_dout_oe <= 1'b0;
      cfg_wr <= 1'b0; cfg_addr <= 7'h00; cfg_data <= 8'h00;
      core_reset <= 1'b0; dx_rd_q <= 1'b0; dy_rd_q <= 1'b0;
    end else begin
      cfg_wr     <= 1'b0;
      core_reset <= 1'b0;
      if (!sel) begin
        st_q <= ST_ADDR;
        bit_q <= 3'd0;
        bidx_q <= 3'd0;
        burst_q <= 1'b0;
        oe_arm_q <= 1'b0;
        ser_dout_oe <= 1'b0;
      end else begin
        if (sck_r)
          sh_q <= sh_in;
        if (sck_r && st_q != ST_LOCK)
          bit_q <= bit_q + 3'd1;
        // Data changes only on falling edges and stands until the next
        if (sck_f && oe_arm_q) begin
          ser_dout_oe <= 1'b1;
          ser_dout    <= tx_q[7];
          tx_q        <= {tx_q[6:0], 1'b0};
        end
        case (st_q)
          ST_ADDR: if (addr_done) begin
            addr_q <= sh_in[6:0];
            if (sh_in[7]) begin
              st_q <= ST_WDAT;
            end else begin
              st_q <= ST_RDAT;
              oe_arm_q <= 1'b1;
              if (sh_in[6:0] == `MSSP_ADDR_BURST) begin
                burst_q <= 1'b1;
                // Snapshot so bytes run back to back at full rate
                bbuf_q <= {moved_flag, 7'h00, dx_q, dy_q, squal,
                           shutter, peak_pixel};
                tx_q <= {moved_flag, 7'h00};
                bidx_q <= 3'd1;
              end else begin
                tx_q <= rd_mux(sh_in[6:0]);
              end
            end
          end
          ST_WDAT: if (wr_done) begin
            st_q <= ST_ADDR;
            cfg_wr <= 1'b1;
            cfg_addr <= addr_q;
            cfg_data <= sh_in;
            if (addr_q == `MSSP_ADDR_PUP_RST &&
                sh_in == `MSSP_PUP_RST_KEY)
              core_reset <= 1'b1;
          end
          ST_RDAT: if (rd_byte) begin
            if (burst_q) begin
              if (bidx_q == `MSSP_BURST_BYTES) begin
                st_q <= ST_LOCK;
              end else begin
                tx_q <= bbuf_q[55 - 8*bidx_q -: 8];
                bidx_q <= bidx_q + 3'd1;
              end
              // Early ending after X is harmless: state resets
              if (bidx_q == 3'd2) dx_rd_q <= 1'b1;
              if (bidx_q == 3'd3) dy_rd_q <= 1'b1;
            end else begin
              st_q <= ST_ADDR;
              oe_arm_q <= 1'b0;
              if (addr_q == `MSSP_ADDR_DX) dx_rd_q <= 1'b1;
              if (addr_q == `MSSP_ADDR_DY) dy_rd_q <= 1'b1;
            end
          end
          ST_LOCK: oe_arm_q <= 1'b0;
          default: st_q <= ST_ADDR;
        endcase
      end
      if (wr_motion || (dx_rd_q && dy_rd_q) || core_reset) begin
        dx_rd_q <= 1'b0;
        dy_rd_q <= 1'b0;
      end
    end
  end

  //--------------------------------------------------------------
  // Displacement accumulation and moved flag
  //--------------------------------------------------------------
  wire clr_motion = wr_motion | (dx_rd_q & dy_rd_q) | core_reset;

  // A new event in the clearing cycle survives: set wins
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dx_q <= 8'h00; dy_q <= 8'h00; moved_flag <= 1'b0;
      motion_low <= 1'b1;
    end else begin
      if (motion_event) begin
        dx_q <= (clr_motion ? 8'h00 : dx_q) + motion_dx;
        dy_q <= (clr_motion ? 8'h00 : dy_q) + motion_dy;
        moved_flag <= 1'b1;
      end else if (clr_motion) begin
        dx_q <= 8'h00; dy_q <= 8'h00;
        moved_flag <= 1'b0;
      end
      motion_low <= ~(motion_event | (moved_flag & ~clr_motion));
    end
  end

  //--------------------------------------------------------------
  // Rest-level downshift and motion check timing
  //--------------------------------------------------------------
  reg [63:0] idle_q, chk_q;
  wire [63:0] chk_per = (rest_level == 2'd1) ? CHK1_CYC :
                        (rest_level == 2'd2) ? CHK2_CYC : CHK3_CYC;

  // Level 0 is run; idle time since last motion picks the level
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 64'h0; chk_q <= 64'h0;
      rest_level <= 2'd0; motion_check <= 1'b0;
    end else begin
      motion_check <= 1'b0;
      if (motion_event || core_reset) begin
        idle_q <= 64'h0;
        rest_level <= 2'd0;
        chk_q <= 64'h0;
      end else begin
        idle_q <= idle_q + 64'h1;
        if (rest_level == 2'd0 && idle_q >= DS1_CYC)
          rest_level <= 2'd1;
        else if (rest_level == 2'd1 && idle_q >= DS1_CYC + DS2_CYC)
          rest_level <= 2'd2;
        else if (rest_level == 2'd2 &&
                 idle_q >= DS1_CYC + DS2_CYC + DS3_CYC)
          rest_level <= 2'd3;
        if (rest_level != 2'd0) begin
          if (chk_q + 64'h1 >= chk_per) begin
            chk_q <= 64'h0;
            motion_check <= 1'b1;
          end else begin
            chk_q <= chk_q + 64'h1;
          end
        end
      end
    end
  end

endmodule // mssp_port

// ===== verification/mssp_host.sv
// Host model: serial bus master for the motion serial port
module mssp_host (
  // Clock and device pins
  input  wire logic       clk_sys,
  input  wire logic       ser_dout,
  input  wire logic       ser_dout_oe,
  output logic            port_select_low,
  output logic            ser_clk,
  output logic            ser_din,
  // Read results
  output logic [7:0]      rx_byte,
  output logic            rx_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------
  // Framing and bit shifting, clock idles high between frames
  // --------------------------------------------------------------
  initial begin
    port_select_low = 1'b1;
    ser_clk = 1'b1;
    ser_din = 1'b0;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end
  // Idle data line flips so a stale value never looks valid
  task automatic frame(input logic s);
    @(posedge clk_sys);
    port_select_low <= s;
    ser_din <= ~ser_din;
    repeat (6) @(posedge clk_sys);
  endtask
  // Data changes on the falling edge, sampled at the rising one
  task automatic sh(input logic [7:0] tx, input int n, input bit rd);
    logic [7:0] v;
    v = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      @(posedge clk_sys);
      ser_clk <= 1'b0;
      ser_din <= tx[i];
      repeat (4) @(posedge clk_sys);
      v[i] = ser_dout_oe ? ser_dout : 1'bz;
      ser_clk <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    if (rd) begin
      @(posedge clk_sys);
      rx_byte <= v;
      rx_stb <= 1'b1;
      @(posedge clk_sys);
      rx_stb <= 1'b0;
    end
  endtask
  // Long hold after a write covers both write spacings
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    frame(1'b0);
    sh({1'b1, a}, 8, 1'b0);
    sh(d, 8, 1'b0);
    repeat (3000) @(posedge clk_sys);
    frame(1'b1);
  endtask
  task automatic rd(input logic [6:0] a);
    frame(1'b0);
    sh({1'b0, a}, 8, 1'b0);
    repeat (400) @(posedge clk_sys);
    sh(8'h00, 8, 1'b1);
    repeat (50) @(posedge clk_sys);
    frame(1'b1);
  endtask
  // A full burst is followed by a write that must be refused
  task automatic burst(input int n);
    frame(1'b0);
    sh(8'h42, 8, 1'b0);
    repeat (400) @(posedge clk_sys);
    repeat (n) sh(8'h00, 8, 1'b1);
    if (n == 7) begin
      sh(8'h91, 8, 1'b0);
      sh(8'h3c, 8, 1'b0);
    end
    frame(1'b1);
    repeat (3000) @(posedge clk_sys);
  endtask
endmodule // mssp_host

// ===== verification/mssp_port_sva.sv
// Checker: serial pin and motion status assertions
module mssp_port_chk (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       port_select_low,
  input wire logic       ser_clk,
  input wire logic       ser_dout,
  input wire logic       ser_dout_oe,
  input wire logic       motion_event,
  input wire logic       motion_low,
  input wire logic [1:0] rest_level,
  input wire logic       motion_check,
  input wire logic       core_reset,
  input wire logic       cfg_wr,
  input wire logic [6:0] cfg_addr,
  input wire logic [7:0] cfg_data
);
  // ----------------------------------------------------------------
  // Properties, all in the system clock domain
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  oe_release_a:
    assert property ($rose(port_select_low) |-> ##[1:5] !ser_dout_oe)
    else $error("data out still driven after deselect");
  oe_idle_a:
    assert property (port_select_low [*6] |-> !ser_dout_oe)
    else $error("data out driven while deselected");
  no_write_idle_a:
    assert property (port_select_low [*8] |-> !cfg_wr)
    else $error("write completed while deselected");
  dout_hold_a:
    assert property (ser_clk [*2] ##0 ser_dout_oe |-> $stable(ser_dout))
    else $error("data out moved while serial clock high");
  motion_pin_a:
    assert property (motion_event |-> ##[1:3] !motion_low)
    else $error("motion pin not low after motion");
  reset_key_a:
    assert property (core_reset |->
      ##[0:1] (cfg_addr == 7'h3a && cfg_data == 8'h5a))
    else $error("core reset without reset key");
  reset_pulse_a:
    assert property (cfg_wr && cfg_addr == 7'h3a && cfg_data == 8'h5a
      |-> $past(core_reset) or ##[0:1] core_reset)
    else $error("reset key did not reset core");
  run_on_motion_a:
    assert property (motion_event |-> ##[1:3] rest_level == 2'd0)
    else $error("rest level not cleared by motion");
  check_rest_a:
    assert property (motion_check |->
      rest_level != 2'd0 || $past(rest_level) != 2'd0)
    else $error("motion check while running");
endmodule // mssp_port_chk

bind mssp_port mssp_port_chk mssp_port_chk_i (.clk_sys, .rst_n,
  .port_select_low, .ser_clk, .ser_dout, .ser_dout_oe, .motion_event,
  .motion_low, .rest_level, .motion_check, .core_reset, .cfg_wr,
  .cfg_addr, .cfg_data);

// ===== verification/tb_top.sv
// Testbench: motion serial port against a host model
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Signals, design, host and scoreboard
  // ----------------------------------------------------------------
  logic clk_sys = 0, rst_n, motion_event;
  logic [7:0] motion_dx, motion_dy, squal, peak_pixel;
  logic [15:0] shutter;
  wire port_select_low, ser_clk, ser_din, ser_dout, ser_dout_oe, rx_stb;
  wire motion_low, motion_check, core_reset, cfg_wr;
  wire [1:0] rest_level;
  wire [6:0] cfg_addr;
  wire [7:0] cfg_data, rx_byte;
  int mismatches = 0, comparisons = 0, seed = 32'h510d;
  logic [15:0] expq[$];
  always #5 clk_sys = ~clk_sys;
  // Short downshift counts keep the rest test brief; the third check
  // period keeps its full length, so no check pulse comes at level 3
  localparam int DS1 = 100, DS2 = 200, DS3 = 300, CHK1 = 10, CHK2 = 20;
  mssp_port #(.DS1_CYC(64'(DS1)), .DS2_CYC(64'(DS2)),
    .DS3_CYC(64'(DS3)), .CHK1_CYC(64'(CHK1)), .CHK2_CYC(64'(CHK2)))
    mssp_port_i (
    .clk_sys, .rst_n, .port_select_low, .ser_clk, .ser_din, .ser_dout,
    .ser_dout_oe, .motion_event, .motion_dx, .motion_dy, .squal,
    .shutter, .peak_pixel, .motion_low, .rest_level, .motion_check,
    .core_reset, .cfg_wr, .cfg_addr, .cfg_data);
  mssp_host mssp_host_i (.clk_sys, .ser_dout, .ser_dout_oe,
    .port_select_low, .ser_clk, .ser_din, .rx_byte, .rx_stb);
  task automatic chk(input string nm, input logic [15:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // An unexpected result meets an unknown note and fails
  function automatic logic [15:0] pop();
    return expq.size() ? expq.pop_front() : 16'hxxxx;
  endfunction
  always @(posedge clk_sys) begin
    if (cfg_wr === 1'b1) chk("write", pop(), {1'b1, cfg_addr, cfg_data});
    if (rx_stb === 1'b1) chk("read", pop(), {8'h00, rx_byte});
  end
  // Check spacing, compared only between two pulses at one rest level
  int gap = 0;
  logic [1:0] lvl_q = 2'd0;
  function automatic int per(input logic [1:0] l);
    return (l == 2'd1) ? CHK1 : CHK2;
  endfunction
  always @(posedge clk_sys) begin
    if (motion_check === 1'b1) begin
      if (lvl_q == rest_level)
        chk("check_period", 16'(per(lvl_q)), 16'(gap));
      gap <= 1;
      lvl_q <= rest_level;
    end else begin
      gap <= gap + 1;
      if (rest_level == 2'd0) lvl_q <= 2'd0;
    end
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic w(input logic [6:0] a, input logic [7:0] d);
    expq.push_back({1'b1, a, d});
    mssp_host_i.wr(a, d);
  endtask
  task automatic r(input logic [6:0] a, input logic [7:0] e);
    expq.push_back({8'h00, e});
    mssp_host_i.rd(a);
  endtask
  task automatic evt();
    @(posedge clk_sys);
    motion_event <= 1'b1;
    motion_dx <= 8'($random(seed));
    motion_dy <= 8'($random(seed));
    @(posedge clk_sys);
    motion_event <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic pin(input logic e);
    chk("motion_low", {15'h0, e}, {15'h0, motion_low});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    rst_n <= 1'b0;
    motion_event <= 1'b0;
    motion_dx <= 8'h00;
    motion_dy <= 8'h00;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    squal <= 8'($random(seed));
    shutter <= 16'($random(seed));
    peak_pixel <= 8'($random(seed));
    repeat (4) @(posedge clk_sys);
    w(7'h3a, 8'h5a);
    w(7'h3a, 8'h5b);
    w(7'h28, 8'hfe);
    $display("test power_up done");
    evt();
    pin(1'b0);
    r(7'h02, 8'h80);
    r(7'h03, motion_dx);
    r(7'h04, motion_dy);
    pin(1'b1);
    evt();
    w(7'h02, 8'h00);
    pin(1'b1);
    $display("test motion done");
    mssp_host_i.frame(1'b0);
    mssp_host_i.sh(8'h9f, 5, 1'b0);
    mssp_host_i.frame(1'b1);
    repeat (3000) @(posedge clk_sys);
    w(7'h11, 8'ha5);
    mssp_host_i.sh(8'h95, 8, 1'b0);
    mssp_host_i.sh(8'h6a, 8, 1'b0);
    $display("test abort done");
    evt();
    expq.push_back(16'h0080);
    expq.push_back({8'h00, motion_dx});
    expq.push_back({8'h00, motion_dy});
    expq.push_back({8'h00, squal});
    expq.push_back({8'h00, shutter[15:8]});
    expq.push_back({8'h00, shutter[7:0]});
    expq.push_back({8'h00, peak_pixel});
    mssp_host_i.burst(7);
    pin(1'b1);
    evt();
    expq.push_back(16'h0080);
    expq.push_back({8'h00, motion_dx});
    mssp_host_i.burst(2);
    pin(1'b0);
    r(7'h04, motion_dy);
    pin(1'b1);
    $display("test burst done");
    evt();
    for (int lv = 1; lv <= 3; lv++) begin
      // Thresholds add up from the last motion: 100, 300 and 600
      repeat (lv == 1 ? 150 : lv == 2 ? 250 : 300) @(posedge clk_sys);
      chk("rest_level", 16'(lv), {14'h0, rest_level});
    end
    $display("test rest done");
    repeat (10) @(posedge clk_sys);
    chk("pending", 16'h0000, 16'(expq.size()));
    test_done();
  end
  // Run is about 30000 cycles; this bound cuts a hang
  initial begin
    repeat (90000) @(posedge clk_sys);
    mismatches++;
    test_done();
  end
endmodule // tb_top
